// [hw/mds_ctrl.sv]
`timescale 1ns/1ns
module mds_ctrl
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire mds_pkg::mds_avreq_s av_req,
   output logic                   av_waitrequest,
   output logic [31:0]            av_readdata,
   input  wire logic              ref_west,
   input  wire logic              ref_east,
   input  wire logic              early_det,
   input  wire logic              late_det,
   input  wire logic              start_early,
   input  wire logic              start_late,
   output mds_pkg::mds_pad_s      pad_ctrl,
   output logic                   ref_pulse,
   output logic                   multiframe_clk,
   output logic                   osc_sync_pulse,
   output logic                   sync_window,
   output logic [7:0]             applied_adjust_value,
   output logic [7:0]             dataflow_offset,
   output logic                   sync_alt_mode,
   output logic                   sync_sub1_mode
);
   import mds_pkg::*;

   // ***************************************************
   // Register storage
   // ***************************************************
   logic [7:0] main_r, io_r, misca_r, manadj_r, miscb_r, offs_r;
   logic [7:0] winlo_r, winhi_r, mfper_r, mfpre_r, cntpre_r;
   logic [7:0] adj_r, errst_r, dcnt_r, ensmp_r;
   logic [3:0] lcnt_r;
   logic [1:0] enph_r;
   logic       locked_r, serr_r, ref_d_r, rd_pend_r;
   mds_state_e state_r;
   logic [7:0] mf_cnt_r, pre_cnt_r, win_cnt_r;
   logic       pre_run_r;

   // Word index decode; the low two byte address bits select nothing
   function automatic logic [7:0] reg_idx(input logic [9:0] a);
      reg_idx = a[9:2];
   endfunction : reg_idx

   wire logic [7:0] idx  = reg_idx(av_req.address);
   wire logic       wr   = av_req.write & av_req.byteenable[0];
   wire logic       en   = main_r[MAIN_EN];
   wire logic       man  = main_r[MAIN_MAN];
   wire logic [1:0] chk  = main_r[MAIN_CHK_LO+1:MAIN_CHK_LO];
   wire logic [1:0] mode = main_r[MAIN_MOD_LO+1:MAIN_MOD_LO];
   wire logic       ref_sel = main_r[MAIN_EW] ? ref_east : ref_west; // RULE3
   wire logic       ref_rise = ref_sel & ~ref_d_r;
   logic            check_ok;

   // ***************************************************
   // Control register writes
   // ***************************************************
   // Reads take one extra cycle so read data come from flops
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         main_r   <= RST_MAIN;
         io_r     <= RST_IO;
         misca_r  <= RST_MISCA;
         manadj_r <= RST_MANADJ;
         miscb_r  <= RST_MISCB;
         offs_r   <= RST_OFFS;
         winlo_r  <= RST_WINLO;
         winhi_r  <= RST_WINHI;
         mfper_r  <= RST_MFPER;
         mfpre_r  <= RST_MFPRE;
         cntpre_r <= RST_CNTPRE;
      end
      else if (wr)
      begin
         case (idx)
            IDX_MAIN:   main_r   <= av_req.writedata[7:0];
            IDX_IO:     io_r     <= av_req.writedata[7:0] & WR_MASK_IO;
            IDX_MISCA:  misca_r  <= av_req.writedata[7:0] & WR_MASK_MISCA;
            IDX_MANADJ: manadj_r <= av_req.writedata[7:0];
            IDX_MISCB:  miscb_r  <= av_req.writedata[7:0] & WR_MASK_MISCB;
            IDX_OFFS:   offs_r   <= av_req.writedata[7:0];
            IDX_WINLO:  winlo_r  <= av_req.writedata[7:0]; // RULE10
            IDX_WINHI:  winhi_r  <= av_req.writedata[7:0]; // RULE10
            IDX_MFPER:  mfper_r  <= av_req.writedata[7:0]; // RULE11
            IDX_MFPRE:  mfpre_r  <= av_req.writedata[7:0]; // RULE12
            IDX_CNTPRE: cntpre_r <= av_req.writedata[7:0];
            default:    ;
         endcase
      end
   end

   // ***************************************************
   // Bus answer
   // ***************************************************
   // Writes finish at once; reads stall exactly one cycle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rd_pend_r <= 1'b0;
      else
         rd_pend_r <= av_req.read & ~rd_pend_r;
   end

   assign av_waitrequest = av_req.read & ~rd_pend_r;

   // Status registers are read only; writes to them are dropped
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         av_readdata <= 32'h0000_0000;
      else if (av_req.read & ~rd_pend_r)
      begin
         case (idx)
            IDX_MAIN:   av_readdata <= {24'h000000, main_r};
            IDX_IO:     av_readdata <= {24'h000000, io_r};
            IDX_MISCA:  av_readdata <= {24'h000000, misca_r};
            IDX_MANADJ: av_readdata <= {24'h000000, manadj_r};
            IDX_MISCB:  av_readdata <= {24'h000000, miscb_r};
            IDX_OFFS:   av_readdata <= {24'h000000, offs_r};
            IDX_WINLO:  av_readdata <= {24'h000000, winlo_r};
            IDX_WINHI:  av_readdata <= {24'h000000, winhi_r};
            IDX_MFPER:  av_readdata <= {24'h000000, mfper_r};
            IDX_MFPRE:  av_readdata <= {24'h000000, mfpre_r};
            IDX_CNTPRE: av_readdata <= {24'h000000, cntpre_r};
            IDX_ADJ:    av_readdata <= {24'h000000, adj_r}; // RULE14 RULE17
            IDX_ERRST:  av_readdata <= {24'h000000, errst_r};
            IDX_STATE:  av_readdata <= {24'h000000, (state_r != MDS_IDLE), serr_r, 2'h0, state_r}; // RULE15
            IDX_LOCK:   av_readdata <= {24'h000000, locked_r, 7'h00}; // RULE16
            IDX_LCNT:   av_readdata <= {28'h0000000, lcnt_r};
            IDX_DCNT:   av_readdata <= {24'h000000, dcnt_r};
            IDX_ENSMP:  av_readdata <= {24'h000000, ensmp_r};
            IDX_ENPH:   av_readdata <= {30'h00000000, enph_r};
            default:    av_readdata <= 32'h0000_0000;
         endcase
      end
   end

   // ***************************************************
   // Reference edge and lock condition
   // ***************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ref_d_r <= 1'b0;
      else
         ref_d_r <= ref_sel;
   end

   // Mode 11 tolerates jitter by accepting either crossed pair
   always_comb
   begin
      case (chk)
         2'h0:    check_ok = early_det & late_det; // RULE1
         2'h1:    check_ok = late_det; // RULE1
         2'h2:    check_ok = early_det; // RULE1
         default: check_ok = (start_early & late_det) | (start_late & early_det); // RULE1
      endcase
   end

   // ***************************************************
   // Sync state machine
   // ***************************************************
   // A failed check after lock is a lockout; relock only if asked
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r  <= MDS_IDLE;
         lcnt_r   <= 4'h0;
         locked_r <= 1'b0;
         serr_r   <= 1'b0;
      end
      else if (!en)
      begin
         state_r  <= MDS_IDLE; // RULE5
         lcnt_r   <= 4'h0;
         locked_r <= 1'b0;
      end
      else
      begin
         serr_r <= (mode != MOD_ALT) && (mode != MOD_SUB1); // RULE4
         case (state_r)
            MDS_IDLE:
               state_r <= MDS_SEARCH;
            MDS_SEARCH:
               if (ref_rise)
               begin
                  state_r <= MDS_CHECK;
                  lcnt_r  <= 4'h0;
               end
            MDS_CHECK:
               if (ref_rise)
               begin
                  if (!check_ok)
                     lcnt_r <= 4'h0;
                  else if (lcnt_r >= miscb_r[3:0]) // RULE8
                  begin
                     state_r  <= MDS_LOCKED;
                     locked_r <= 1'b1;
                  end
                  else
                     lcnt_r <= lcnt_r + 4'h1; // RULE8
               end
            MDS_LOCKED:
               if (ref_rise && !check_ok)
               begin
                  state_r  <= MDS_LOCKOUT;
                  locked_r <= 1'b0;
               end
            MDS_LOCKOUT:
               if (miscb_r[MISCB_RELK])
                  state_r <= MDS_SEARCH; // RULE7
            default:
            begin
               state_r <= MDS_IDLE;
               serr_r  <= 1'b1;
            end
         endcase
      end
   end

   // ***************************************************
   // Adjustment delay
   // ***************************************************
   // Auto mode walks the delay from the manual seed while checks fail
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         adj_r <= RST_MANADJ;
      else if (man || state_r == MDS_IDLE || state_r == MDS_SEARCH)
         adj_r <= manadj_r; // RULE2 RULE13
      else if (state_r == MDS_CHECK && ref_rise && !check_ok)
         adj_r <= adj_r + 8'h01; // RULE2
   end

   // Diagnostic status copies
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         errst_r <= 8'h00;
         dcnt_r  <= 8'h00;
         ensmp_r <= 8'h00;
         enph_r  <= 2'h0;
      end
      else
      begin
         errst_r <= {1'b0, 1'b0, 1'b0, 1'b0, early_det, late_det, 1'b0, state_r != MDS_IDLE};
         dcnt_r  <= ref_rise ? 8'h00 : dcnt_r + 8'h01;
         ensmp_r <= {ensmp_r[6:0], ref_sel};
         enph_r  <= {start_early, start_late};
      end
   end

   // ***************************************************
   // Internal reference pulse, preset and multiframe clock
   // ***************************************************
   // Pulse fires on each selected reference edge while enabled and main control bit 4 is clear, locked or not
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ref_pulse <= 1'b0;
      else
         ref_pulse <= en & ~main_r[MAIN_SRDIS] & ref_rise; // RULE18
   end

   // Preset counter delays the multiframe restart after the pulse
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pre_run_r <= 1'b0;
         pre_cnt_r <= 8'h00;
      end
      else if (ref_pulse)
      begin
         pre_run_r <= 1'b1;
         pre_cnt_r <= mfpre_r; // RULE12
      end
      else if (pre_run_r)
      begin
         if (pre_cnt_r == 8'h00)
            pre_run_r <= 1'b0;
         else
            pre_cnt_r <= pre_cnt_r - 8'h01;
      end
   end

   wire logic mf_restart = pre_run_r && (pre_cnt_r == 8'h00);

   // Period of zero holds the clock high rather than dividing by nothing
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         mf_cnt_r <= 8'h00;
      else if (mf_restart || mf_cnt_r + 8'h01 >= mfper_r)
         mf_cnt_r <= 8'h00; // RULE11
      else
         mf_cnt_r <= mf_cnt_r + 8'h01;
   end

   assign multiframe_clk = (mf_cnt_r < {1'b0, mfper_r[7:1]}) | (mfper_r == 8'h00);

   // Oscillator sync follows the multiframe restart when enabled
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         osc_sync_pulse <= 1'b0;
      else
         osc_sync_pulse <= mf_restart & misca_r[MISCA_NCO]; // RULE19
   end

   // ***************************************************
   // Sync window
   // ***************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync_window <= 1'b0;
         win_cnt_r   <= 8'h00;
      end
      else if (win_cnt_r == 8'h00)
      begin
         sync_window <= ~sync_window;
         win_cnt_r   <= sync_window ? winlo_r : winhi_r; // RULE10
      end
      else
         win_cnt_r <= win_cnt_r - 8'h01;
   end

   // ***************************************************
   // Outputs
   // ***************************************************
   assign applied_adjust_value = adj_r; // RULE14
   assign dataflow_offset      = offs_r; // RULE9
   assign sync_alt_mode        = en & (mode == MOD_ALT); // RULE4
   assign sync_sub1_mode       = en & (mode == MOD_SUB1); // RULE4
   assign pad_ctrl.east_ref_buffer_on      = io_r[IO_PON_E]; // RULE20
   assign pad_ctrl.west_ref_buffer_on      = io_r[IO_PON_W]; // RULE20
   assign pad_ctrl.east_ref_termination_on = io_r[IO_RT_E]; // RULE6
   assign pad_ctrl.west_ref_termination_on = io_r[IO_RT_W]; // RULE6

   // ***************************************************
   // Checks
   // ***************************************************
   // Enable is folded into the sequence; a sequence cannot be an operand of a logical and
   sequence s_lock_good;
      en && ref_rise && check_ok && state_r == MDS_CHECK && lcnt_r >= miscb_r[3:0];
   endsequence

   AST_LOCK_SET: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
      s_lock_good |=> locked_r) else $error("lock not declared");
   AST_LOCK_BIT: assert property (@(posedge clk) disable iff (!rst_n) // RULE16
      locked_r |-> state_r == MDS_LOCKED) else $error("lock bit without locked state");
   AST_DISABLE: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
      !en |=> state_r == MDS_IDLE && !locked_r) else $error("disabled but active");
   AST_MANUAL: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
      (man && $stable(manadj_r)) |=> adj_r == $past(manadj_r)) else $error("manual delay not applied");
   AST_RELOCK: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
      (en && state_r == MDS_LOCKOUT && !miscb_r[MISCB_RELK]) |=> state_r == MDS_LOCKOUT)
      else $error("relock without request");
   AST_SRDIS: assert property (@(posedge clk) disable iff (!rst_n) // RULE18
      main_r[MAIN_SRDIS] |=> !ref_pulse) else $error("pulse while disabled");
   AST_NCO: assert property (@(posedge clk) disable iff (!rst_n) // RULE19
      osc_sync_pulse |-> $past(misca_r[MISCA_NCO]) && $past(mf_restart)) else $error("bad oscillator sync");
   AST_CHK0: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
      (chk == 2'h0 && !(early_det && late_det)) |-> !check_ok) else $error("check mode 00 wrong");
endmodule : mds_ctrl

// [pkg/mds_pkg.sv]
// Summary of operation
// RULE1 - Lock-check field picks lock condition from early, late and start flags.
// RULE2 - Main control bit 5 selects automatic or manual adjustment delay control.
// RULE3 - Main control bit 3 selects west (0) or east (1) reference input.
// RULE4 - Two-bit scheme field: 00 alternate mode, 10 subclass 1 mode, others unused.
// RULE5 - Main control bit 0 enables the whole synchronization function; the sync window and multiframe clock here keep running while it is clear.
// RULE6 - Bits 2 and 0 switch east and west input termination on.
// RULE7 - Relock bit set makes the logic retry lock after a lockout.
// RULE8 - Four-bit count of consecutive good checks needed before lock.
// RULE9 - Signed eight-bit offset adds -128..127 clock delay to data flow.
// RULE10 - Two eight-bit registers set window low (0Fh) and high (07h) time.
// RULE11 - Eight-bit register sets local multiframe clock period, reset 10h.
// RULE12 - Eight-bit preset delays multiframe clock after reference pulse, reset 04h.
// RULE13 - Manual adjust register seeds auto delay, or sets delay directly in manual.
// RULE14 - Read-only register reports the adjustment delay currently applied.
// RULE15 - State status shows busy bit 7, error bit 6, state code bits 3..0.
// RULE16 - Lock status bit 7 reads one once reference is found and locked.
// RULE17 - Status registers are read-only and meaningless until logic updates them.
// RULE18 - Main control bit 4 set stops internal reference pulse generation.
// RULE19 - Misc control bit 6 lets the sync event also align the oscillator.
// RULE20 - Reference control bits 5 and 4 enable east and west input buffers.
package mds_pkg;
   // ***************************************************
   // Register indices (byte address is four times these)
   // ***************************************************
   localparam logic [7:0] IDX_MAIN   = 8'hA0;
   localparam logic [7:0] IDX_IO     = 8'hA2;
   localparam logic [7:0] IDX_MISCA  = 8'hA3;
   localparam logic [7:0] IDX_MANADJ = 8'hA4;
   localparam logic [7:0] IDX_MISCB  = 8'hA6;
   localparam logic [7:0] IDX_OFFS   = 8'hA7;
   localparam logic [7:0] IDX_WINLO  = 8'hA8;
   localparam logic [7:0] IDX_WINHI  = 8'hA9;
   localparam logic [7:0] IDX_MFPER  = 8'hAA;
   localparam logic [7:0] IDX_MFPRE  = 8'hAB;
   localparam logic [7:0] IDX_CNTPRE = 8'hAC;
   localparam logic [7:0] IDX_ADJ    = 8'hB5;
   localparam logic [7:0] IDX_ERRST  = 8'hB6;
   localparam logic [7:0] IDX_STATE  = 8'hB7;
   localparam logic [7:0] IDX_LOCK   = 8'hB8;
   localparam logic [7:0] IDX_LCNT   = 8'hBA;
   localparam logic [7:0] IDX_DCNT   = 8'hBB;
   localparam logic [7:0] IDX_ENSMP  = 8'hBC;
   localparam logic [7:0] IDX_ENPH   = 8'hBD;
   // ***************************************************
   // Reset values
   // ***************************************************
   localparam logic [7:0] RST_MAIN   = 8'hE0;
   localparam logic [7:0] RST_IO     = 8'h30;
   localparam logic [7:0] RST_MISCA  = 8'h10;
   localparam logic [7:0] RST_MANADJ = 8'h80;
   localparam logic [7:0] RST_MISCB  = 8'h0F;
   localparam logic [7:0] RST_OFFS   = 8'h00;
   localparam logic [7:0] RST_WINLO  = 8'h0F;
   localparam logic [7:0] RST_WINHI  = 8'h07;
   localparam logic [7:0] RST_MFPER  = 8'h10;
   localparam logic [7:0] RST_MFPRE  = 8'h04;
   localparam logic [7:0] RST_CNTPRE = 8'h02;
   // ***************************************************
   // Field positions
   // ***************************************************
   localparam int MAIN_EN     = 0;
   localparam int MAIN_MOD_LO = 1;
   localparam int MAIN_EW     = 3;
   localparam int MAIN_SRDIS  = 4;
   localparam int MAIN_MAN    = 5;
   localparam int MAIN_CHK_LO = 6;
   localparam int IO_RT_W     = 0;
   localparam int IO_RT_E     = 2;
   localparam int IO_PON_W    = 4;
   localparam int IO_PON_E    = 5;
   localparam int MISCA_NCO   = 6;
   localparam int MISCB_RELK  = 4;
   localparam logic [1:0] MOD_ALT  = 2'h0;
   localparam logic [1:0] MOD_SUB1 = 2'h2;
   localparam logic [7:0] WR_MASK_MISCB = 8'h1F;
   localparam logic [7:0] WR_MASK_MISCA = 8'h7F;
   localparam logic [7:0] WR_MASK_IO    = 8'h35;

   typedef enum logic [3:0] {MDS_IDLE, MDS_SEARCH, MDS_CHECK, MDS_LOCKED, MDS_LOCKOUT} mds_state_e;

   // Avalon-MM request
   typedef struct packed {
      logic [9:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } mds_avreq_s;

   // Pad controls toward the reference input buffers
   typedef struct packed {
      logic east_ref_buffer_on;
      logic west_ref_buffer_on;
      logic east_ref_termination_on;
      logic west_ref_termination_on;
   } mds_pad_s;
endpackage : mds_pkg

// [test/mds_ref_src.sv]
`timescale 1ns/1ns
// ***************************************************
// Reference source on the far side of the sync block
// ***************************************************
module mds_ref_src
#(
   parameter int PERIOD = 20
)
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic run,
   input  wire logic east_sel,
   output logic      ref_west,
   output logic      ref_east
);
   logic [7:0] cnt_r;
   // Free period counter, parked while the source is stopped
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_r <= 8'h00;
      else if (!run || cnt_r == 8'(PERIOD - 1))
         cnt_r <= 8'h00;
      else
         cnt_r <= cnt_r + 8'h01;
   end
   // One-cycle pulse on the chosen line only; the idle line rests low like a parked buffer
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ref_west <= 1'b0;
         ref_east <= 1'b0;
      end
      else
      begin
         ref_west <= run && !east_sel && cnt_r == 8'(PERIOD - 1);
         ref_east <= run && east_sel && cnt_r == 8'(PERIOD - 1);
      end
   end
endmodule : mds_ref_src

// [test/test_mds_ctrl.sv]
`timescale 1ns/1ns
module test_mds_ctrl;
   import mds_pkg::*;
   // ***************************************************
   // Signals
   // ***************************************************
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   mds_avreq_s req = '0;
   logic av_waitrequest, ref_west, ref_east, ref_pulse, multiframe_clk, osc_sync_pulse, sync_window;
   logic [31:0] av_readdata;
   logic early_det = 1'b0, late_det = 1'b0, start_early = 1'b0, start_late = 1'b0;
   mds_pad_s pad_ctrl;
   logic [7:0] applied_adjust_value, dataflow_offset;
   logic sync_alt_mode, sync_sub1_mode;
   int n_fail = 0, compares = 0, n_rp = 0, n_osc = 0;
   always #5 clk = ~clk;
   mds_ctrl dut_u (.clk(clk), .rst_n(rst_n), .av_req(req), .av_waitrequest(av_waitrequest),
      .av_readdata(av_readdata), .ref_west(ref_west), .ref_east(ref_east), .early_det(early_det),
      .late_det(late_det), .start_early(start_early), .start_late(start_late), .pad_ctrl(pad_ctrl),
      .ref_pulse(ref_pulse), .multiframe_clk(multiframe_clk), .osc_sync_pulse(osc_sync_pulse),
      .sync_window(sync_window), .applied_adjust_value(applied_adjust_value),
      .dataflow_offset(dataflow_offset), .sync_alt_mode(sync_alt_mode), .sync_sub1_mode(sync_sub1_mode));
   // Source always runs on the west line so that selecting east must starve the block
   mds_ref_src #(.PERIOD(20)) src_u (.clk(clk), .rst_n(rst_n), .run(1'b1), .east_sel(1'b0),
      .ref_west(ref_west), .ref_east(ref_east));
   // Pulse counters, cleared by the scenarios before each window of interest
   always @(posedge clk)
   begin
      if (ref_pulse === 1'b1) n_rp++;
      if (osc_sync_pulse === 1'b1) n_osc++;
   end
   // ***************************************************
   // Bus and compare tasks
   // ***************************************************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("FAIL %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk
   // Holds the request until waitrequest is seen low at a rising edge, then releases it
   task automatic av_xfer(input logic [7:0] idx, input logic rd, input logic [7:0] d, output logic [7:0] q);
      int i;
      i = 0;
      @(posedge clk);
      req <= '{address: {idx, 2'b00}, read: rd, write: !rd, writedata: {24'h0, d}, byteenable: 4'hF};
      @(posedge clk);
      while (av_waitrequest !== 1'b0 && i < 50)
      begin
         i++;
         @(posedge clk);
      end
      if (i == 50) chk("waitrequest", 32'h0, 32'h1);
      q = av_readdata[7:0];
      req <= '0;
   endtask : av_xfer
   task automatic av_wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] q;
      av_xfer(idx, 1'b0, d, q);
      // Let the stored value reach the outputs before anyone looks at them
      @(posedge clk);
   endtask : av_wr
   task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] q;
      av_xfer(idx, 1'b1, 8'h00, q);
      chk(what, {24'h0, exp}, {24'h0, q});
   endtask : rd_chk
   // ***************************************************
   // Scenarios
   // ***************************************************
   task automatic t_reset;
      logic [7:0] ix [11] = '{IDX_MAIN, IDX_IO, IDX_MISCA, IDX_MANADJ, IDX_MISCB, IDX_OFFS, IDX_WINLO,
                              IDX_WINHI, IDX_MFPER, IDX_MFPRE, IDX_CNTPRE};
      logic [7:0] rv [11] = '{8'hE0, 8'h30, 8'h10, 8'h80, 8'h0F, 8'h00, 8'h0F, 8'h07, 8'h10, 8'h04, 8'h02};
      chk("pad at reset", 32'hC, {28'h0, pad_ctrl});
      chk("multiframe clock at reset", 32'h1, {31'h0, multiframe_clk});
      for (int k = 0; k < 11; k++) rd_chk("reset value", ix[k], rv[k]);
   endtask : t_reset
   task automatic t_regs;
      av_wr(IDX_IO, 8'hFF);
      rd_chk("io mask", IDX_IO, 8'h35);
      chk("pad all on", 32'hF, {28'h0, pad_ctrl});
      av_wr(IDX_IO, 8'h05);
      chk("pad terminations", 32'h3, {28'h0, pad_ctrl});
      av_wr(IDX_MAIN, 8'h20);
      av_wr(IDX_MANADJ, 8'h5A);
      @(posedge clk);
      chk("manual delay port", 32'h5A, {24'h0, applied_adjust_value});
      av_wr(IDX_ADJ, 8'h00);
      rd_chk("applied delay read-only", IDX_ADJ, 8'h5A);
      rd_chk("unmapped read", 8'hA1, 8'h00);
      av_wr(IDX_OFFS, 8'h80);
      chk("offset", 32'h80, {24'h0, dataflow_offset});
   endtask : t_regs
   task automatic t_modes;
      logic [7:0] q;
      for (int m = 0; m < 4; m++)
      begin
         av_wr(IDX_MAIN, {5'h00, 2'(m), 1'b1});
         chk("alt mode", {31'h0, m == 0}, {31'h0, sync_alt_mode});
         chk("sub1 mode", {31'h0, m == 2}, {31'h0, sync_sub1_mode});
         // State code moves with the reference, so only busy, error and reserved bits are fixed
         av_xfer(IDX_STATE, 1'b1, 8'h00, q);
         chk("busy and state error", {28'h0, 1'b1, m[0], 2'h0}, {28'h0, q[7:4]});
      end
      av_wr(IDX_MAIN, 8'h05);
      av_wr(IDX_MAIN, 8'h04);
      chk("sub1 when disabled", 32'h0, {31'h0, sync_sub1_mode});
   endtask : t_modes
   // Counts internal pulses for a window with the given main control value
   task automatic t_ref(input logic [7:0] main, input logic exp);
      av_wr(IDX_MAIN, main);
      // Skip the pulse launched under the old setting
      @(posedge clk);
      n_rp = 0;
      repeat (100) @(posedge clk);
      chk("ref pulses seen", {31'h0, exp}, {31'h0, n_rp > 0});
   endtask : t_ref
   task automatic t_lock(input logic [1:0] mode, input logic [3:0] dets, input logic exp);
      av_wr(IDX_MAIN, 8'h00);
      {early_det, late_det, start_early, start_late} <= dets;
      av_wr(IDX_MAIN, {mode, 6'h05});
      repeat (300) @(posedge clk);
      rd_chk("lock flag", IDX_LOCK, {exp, 7'h00});
   endtask : t_lock
   task automatic t_relock;
      {early_det, late_det} <= 2'b00;
      repeat (100) @(posedge clk);
      rd_chk("lockout state", IDX_STATE, 8'h84);
      av_wr(IDX_MISCB, 8'h12);
      {early_det, late_det} <= 2'b11;
      repeat (300) @(posedge clk);
      rd_chk("relocked", IDX_LOCK, 8'h80);
   endtask : t_relock
   task automatic t_window;
      int n;
      n = 0;
      av_wr(IDX_WINHI, 8'h02);
      av_wr(IDX_WINLO, 8'h03);
      repeat (30) @(posedge clk);
      while (sync_window !== 1'b0 && n < 40) begin n++; @(posedge clk); end
      while (sync_window !== 1'b1 && n < 40) begin n++; @(posedge clk); end
      n = 0;
      while (sync_window === 1'b1 && n < 40) begin n++; @(posedge clk); end
      chk("window high run", 32'd3, n);
      n = 0;
      while (sync_window === 1'b0 && n < 40) begin n++; @(posedge clk); end
      chk("window low run", 32'd4, n);
   endtask : t_window
   task automatic t_osc(input logic [7:0] v, input logic exp);
      av_wr(IDX_MISCA, v);
      @(posedge clk);
      n_osc = 0;
      repeat (100) @(posedge clk);
      chk("oscillator sync", {31'h0, exp}, {31'h0, n_osc > 0});
   endtask : t_osc
   // ***************************************************
   // Verdict and main sequence
   // ***************************************************
   task automatic wrap_up;
      $display("Counts: n_fail=%0d compares=%0d", n_fail, compares);
      if (n_fail == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : wrap_up
   // Watchdog sized well beyond the few thousand cycles the scenarios need
   initial
   begin
      #400000;
      n_fail++;
      wrap_up();
   end
   initial
   begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_regs();
      t_modes();
      t_ref(8'h01, 1'b1);
      t_ref(8'h09, 1'b0);
      t_ref(8'h11, 1'b0);
      t_ref(8'h00, 1'b0);
      av_wr(IDX_MISCB, 8'h02);
      t_lock(2'b00, 4'b1000, 1'b0);
      t_lock(2'b01, 4'b1000, 1'b0);
      t_lock(2'b01, 4'b0100, 1'b1);
      t_lock(2'b10, 4'b0100, 1'b0);
      t_lock(2'b10, 4'b1000, 1'b1);
      t_lock(2'b11, 4'b1010, 1'b0);
      t_lock(2'b11, 4'b0110, 1'b1);
      t_lock(2'b00, 4'b1100, 1'b1);
      t_relock();
      t_window();
      t_osc(8'h40, 1'b1);
      t_osc(8'h00, 1'b0);
      wrap_up();
   end
endmodule : test_mds_ctrl
